// file: common/pllcg_pkg.sv
// package: register map, field layout, reset values and timing of the clock generator control
package pllcg_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] PLLCG_CSR_ADDR  = 32'h01b7c100;
	localparam logic [31:0] PLLCG_MULT_ADDR = 32'h01b7c110;
	localparam logic [31:0] PLLCG_DIV0_ADDR = 32'h01b7c114;
	localparam logic [31:0] PLLCG_DIV1_ADDR = 32'h01b7c118;
	localparam logic [31:0] PLLCG_DIV2_ADDR = 32'h01b7c11c;
	localparam logic [31:0] PLLCG_DIV3_ADDR = 32'h01b7c120;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PLLCG_PATH_BIT   = 0;
	localparam int PLLCG_PWRDN_BIT  = 1;
	localparam int PLLCG_RST_BIT    = 3;
	localparam int PLLCG_STABLE_BIT = 6;
	localparam int PLLCG_DIV_EN_BIT = 15;
	localparam int PLLCG_RATIO_W    = 5;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic       PLLCG_PATH_RESET  = 1'b0;
	localparam logic       PLLCG_PWRDN_RESET = 1'b0;
	localparam logic       PLLCG_RST_RESET   = 1'b1;
	localparam logic       PLLCG_DIV_EN_RESET = 1'b1;
	localparam logic [4:0] PLLCG_MULT_RESET  = 5'h07;
	localparam logic [4:0] PLLCG_DIV0_RESET  = 5'h00;
	localparam logic [4:0] PLLCG_DIV1_RESET  = 5'h00;
	localparam logic [4:0] PLLCG_DIV2_RESET  = 5'h01;
	localparam logic [4:0] PLLCG_DIV3_RESET  = 5'h01;
	localparam logic [4:0] PLLCG_MULT_MIN    = 5'h04;
	localparam logic [4:0] PLLCG_MULT_MAX    = 5'h19;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int PLLCG_CLOCK_HZ       = 20000000;
	localparam int PLLCG_PLL_RESET_NS   = 125;
	localparam int PLLCG_PLL_RESET_CYC  =
		(PLLCG_PLL_RESET_NS * (PLLCG_CLOCK_HZ / 1000000) + 999) / 1000;
	localparam int PLLCG_STABLE_DEFAULT = 4096;

	// multiplier codes outside x4..x25 are reserved
	function automatic logic pllcg_mult_ok(input logic [4:0] code);
		pllcg_mult_ok = (code >= PLLCG_MULT_MIN) && (code <= PLLCG_MULT_MAX);
	endfunction : pllcg_mult_ok

	// divider register image: enable in bit 15, ratio in the low bits
	function automatic logic [31:0] pllcg_div_word(input logic en,
		input logic [4:0] ratio);
		pllcg_div_word = {16'h0000, en, 10'h000, ratio};
	endfunction : pllcg_div_word

endpackage : pllcg_pkg

// file: dv/pllcg_clock_control_test.sv
// testbench: register access, dividers, path switch and memory clock select
`timescale 1ns/1ps
module pllcg_clock_control_test;
	import pllcg_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int STABLE_N = 8;
	// worst-case lock wait in reference cycles
	localparam int LOCK_N   = 3750;
	logic        clock;
	logic        rst;
	logic        reg_write;
	logic        reg_read;
	logic [31:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_ack;
	logic        pll_output_clock;
	logic        pll_reset_hold;
	logic        pll_power_down;
	logic [4:0]  pll_multiplier;
	logic [4:0]  input_prescaler;
	logic        memif_clock_source_select;
	logic        external_memif_clock_in;
	logic        core_clock;
	logic        peripheral_bus_clock;
	logic        peripheral_clock_output_pin;
	logic        memif_internal_clock;
	logic        memif_clock;
	logic        pll_run;
	int          error_cnt;
	int          n_checks;
	int          c1;
	int          c2;
	int          c3;
	int          c4;

	pllcg_clock_control #(.STABLE_COUNT(STABLE_N)) dut (
		.clock(clock), .rst(rst), .reg_write(reg_write),
		.reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.pll_output_clock(pll_output_clock),
		.pll_reset_hold(pll_reset_hold), .pll_power_down(pll_power_down),
		.pll_multiplier(pll_multiplier), .input_prescaler(input_prescaler),
		.memif_clock_source_select(memif_clock_source_select),
		.external_memif_clock_in(external_memif_clock_in),
		.core_clock(core_clock), .peripheral_bus_clock(peripheral_bus_clock),
		.peripheral_clock_output_pin(peripheral_clock_output_pin),
		.memif_internal_clock(memif_internal_clock),
		.memif_clock(memif_clock));

	initial clock = 1'b0;
	always #25 clock = ~clock;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// entered 1 ns after an edge; ack is due one cycle after the request
	task automatic xfer(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		reg_write = wr;
		reg_read = ~wr;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clock);
		#1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		chk(32'(reg_ack), 32'h1, "ack");
		q = reg_rdata;
		@(posedge clock);
		#1;
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] exp, input string msg);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q & m, exp, msg);
	endtask : rd

	// counts ticks; memif_clock is last cycle's selected source
	task automatic run(input int n);
		logic pv;
		c1 = 0;
		c2 = 0;
		c3 = 0;
		c4 = 0;
		for (int i = 0; i < n; i++) begin
			pll_output_clock = pll_run && (i % 4 < 2);
			external_memif_clock_in = ~external_memif_clock_in;
			pv = memif_clock_source_select ? external_memif_clock_in
				: memif_internal_clock;
			@(posedge clock);
			#1;
			c1 += int'(core_clock);
			c2 += int'(peripheral_bus_clock);
			c3 += int'(memif_internal_clock);
			c4 += int'(peripheral_clock_output_pin);
			chk(32'(peripheral_clock_output_pin),
				32'(peripheral_bus_clock), "pin");
			chk(32'(memif_clock), 32'(pv), "memif");
		end
	endtask : run

	task automatic counts(input int e1, input int e2, input int e3);
		chk(c1, e1, "core ticks");
		chk(c2, e2, "periph ticks");
		chk(c3, e3, "memif ticks");
		chk(c4, e2, "pin ticks");
	endtask : counts

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(PLLCG_CSR_ADDR, '1, 32'h8, "csr reset");
		chk(32'(pll_reset_hold), 32'h1, "hold");
		chk(32'(pll_power_down), 32'h0, "pdn");
		chk(32'(pll_multiplier), 32'h7, "mult out");
		chk(32'(input_prescaler), 32'h0, "presc");
		rd(PLLCG_MULT_ADDR, '1, 32'h7, "mult");
		rd(PLLCG_DIV0_ADDR, '1, 32'h8000, "div0");
		rd(PLLCG_DIV1_ADDR, '1, 32'h8000, "div1");
		rd(PLLCG_DIV2_ADDR, '1, 32'h8001, "div2");
		rd(PLLCG_DIV3_ADDR, '1, 32'h8001, "div3");
		repeat (STABLE_N) @(posedge clock);
		#1;
		rd(PLLCG_CSR_ADDR, '1, 32'h48, "stable");
		$display("test reset done");
	endtask : t_reset

	task automatic t_csr();
		// path bit kept clear: no pll source is running yet
		wr(PLLCG_CSR_ADDR, 32'hfffffffe);
		rd(PLLCG_CSR_ADDR, 32'hfffffffb, 32'h4a, "csr ones");
		chk(32'(pll_reset_hold), 32'h1, "hold set");
		chk(32'(pll_power_down), 32'h1, "pdn set");
		wr(PLLCG_CSR_ADDR, 32'h0);
		rd(PLLCG_CSR_ADDR, '1, 32'h40, "csr zero");
		chk(32'(pll_reset_hold), 32'h0, "hold clr");
		chk(32'(pll_power_down), 32'h0, "pdn clr");
		wr(32'h01b7c124, 32'hffffffff);
		rd(32'h01b7c124, '1, 32'h0, "unmapped");
		$display("test csr done");
	endtask : t_csr

	task automatic t_mult();
		wr(PLLCG_MULT_ADDR, 32'hffffffe0 | 32'h19);
		rd(PLLCG_MULT_ADDR, '1, 32'h19, "x25");
		wr(PLLCG_MULT_ADDR, 32'h1a);
		rd(PLLCG_MULT_ADDR, '1, 32'h19, "rsvd high");
		wr(PLLCG_MULT_ADDR, 32'h3);
		rd(PLLCG_MULT_ADDR, '1, 32'h19, "rsvd low");
		wr(PLLCG_MULT_ADDR, 32'h4);
		chk(32'(pll_multiplier), 32'h4, "x4");
		wr(PLLCG_DIV0_ADDR, 32'h801f);
		chk(32'(input_prescaler), 32'h1f, "presc");
		$display("test mult done");
	endtask : t_mult

	task automatic t_div();
		wr(PLLCG_DIV2_ADDR, 32'h8003);
		wr(PLLCG_DIV1_ADDR, 32'h8001);
		wr(PLLCG_DIV3_ADDR, 32'h8004);
		run(40);
		run(40);
		counts(20, 10, 8);
		wr(PLLCG_DIV3_ADDR, 32'h0004);
		run(10);
		run(40);
		chk(c3, 0, "div off");
		wr(PLLCG_DIV3_ADDR, 32'hffffffff);
		rd(PLLCG_DIV3_ADDR, '1, 32'h801f, "div rsvd");
		// speeding up: core divider first
		wr(PLLCG_DIV1_ADDR, 32'h8000);
		wr(PLLCG_DIV2_ADDR, 32'h8001);
		wr(PLLCG_DIV3_ADDR, 32'h8001);
		memif_clock_source_select = 1'b1;
		run(40);
		memif_clock_source_select = 1'b0;
		run(40);
		counts(40, 20, 20);
		$display("test div done");
	endtask : t_div

	task automatic t_pll();
		pll_run = 1'b1;
		// reset pulse and lock wait, all while still bypassed
		wr(PLLCG_CSR_ADDR, 32'h8);
		repeat (PLLCG_PLL_RESET_CYC) @(posedge clock);
		#1;
		wr(PLLCG_CSR_ADDR, 32'h0);
		repeat (LOCK_N) @(posedge clock);
		#1;
		wr(PLLCG_CSR_ADDR, 32'h1);
		run(16);
		run(32);
		counts(8, 4, 4);
		// switch back waits for a core tick of the pll path
		wr(PLLCG_CSR_ADDR, 32'h0);
		run(16);
		run(8);
		run(16);
		counts(16, 8, 8);
		$display("test pll done");
	endtask : t_pll

	initial begin
		rst = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		pll_output_clock = 1'b0;
		memif_clock_source_select = 1'b0;
		external_memif_clock_in = 1'b0;
		pll_run = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		repeat (8) @(posedge clock);
		#1;
		rst = 1'b0;
		t_reset();
		t_csr();
		t_mult();
		t_div();
		t_pll();
		close_out();
	end

endmodule : pllcg_clock_control_test

// file: hw/pllcg_clock_control.sv
// top: control/status, multiplier and divider registers, clock path selection
//
// Function
// - memory interface clock is external pin or third system clock, by select bit.
// - third system clock comes from the common path through the third post-divider.
// - multiplier and divider writes take effect at run time without reset.
// - second system clock drives peripheral bus and the peripheral clock pin.
// - bit 6 reads 0 until the clock counter finishes, then 1.
// - bit 3 holds PLL reset, reset value 1; writing 0 releases it.
// - bit 1 set powers the PLL down; clear, default, keeps it running.
// - bit 0 clear bypasses to input clock; set uses PLL output.
// - reserved control/status bits read zero and ignore writes.
// - five-bit multiplier, codes x4 to x25 valid, others reserved, reset x7.
// - divider enable in bit 15, default 1; ratio code n divides by n+1.
`timescale 1ns/1ps
module pllcg_clock_control
	import pllcg_pkg::*;
#(
	parameter int STABLE_COUNT = PLLCG_STABLE_DEFAULT
)
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// register port
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata,
	output logic             reg_ack,
	// pll analog side
	input  wire logic        pll_output_clock,
	output logic             pll_reset_hold,
	output logic             pll_power_down,
	output logic [4:0]       pll_multiplier,
	output logic [4:0]       input_prescaler,
	// memory interface source
	input  wire logic        memif_clock_source_select,
	input  wire logic        external_memif_clock_in,
	// system clocks
	output logic             core_clock,
	output logic             peripheral_bus_clock,
	output logic             peripheral_clock_output_pin,
	output logic             memif_internal_clock,
	output logic             memif_clock
);

	typedef struct packed {
		logic        path_select;
		logic        reset_hold;
		logic        power_down;
		logic [4:0]  mult;
		logic [3:0]  div_en;
		logic [19:0] div_ratio;
		logic        stable;
		logic [31:0] stable_cnt;
		logic        path_eff;
		logic        pll_prev;
		logic        memif_clk;
		logic [31:0] rdata;
		logic        ack;
	} pllcg_state_t;

	pllcg_state_t st;
	pllcg_state_t next_st;

	logic core_tick;
	logic periph_tick;
	logic memif_tick;
	logic src_tick;
	logic path_switch;

	// ------------------------------------------------------------
	// source selection
	// ------------------------------------------------------------
	// bypass ticks every reference cycle; pll path ticks on its rising edge
	assign src_tick = st.path_eff ? (pll_output_clock & ~st.pll_prev)
	                              : 1'b1;
	// switching waits for a core boundary so the old period completes
	assign path_switch = (st.path_select != st.path_eff) && core_tick;

	// ------------------------------------------------------------
	// register access and state update
	// ------------------------------------------------------------
	function automatic logic [31:0] read_mux(input pllcg_state_t s,
		input logic [31:0] a);
		logic [31:0] w;
		w = 32'h00000000;
		case (a)
			PLLCG_CSR_ADDR: begin
				w[PLLCG_PATH_BIT]   = s.path_select;
				w[PLLCG_PWRDN_BIT]  = s.power_down;
				w[PLLCG_RST_BIT]    = s.reset_hold;
				w[PLLCG_STABLE_BIT] = s.stable;
			end
			PLLCG_MULT_ADDR: w = {27'h0000000, s.mult};
			PLLCG_DIV0_ADDR: w = pllcg_div_word(s.div_en[0], s.div_ratio[4:0]);
			PLLCG_DIV1_ADDR: w = pllcg_div_word(s.div_en[1], s.div_ratio[9:5]);
			PLLCG_DIV2_ADDR: w = pllcg_div_word(s.div_en[2], s.div_ratio[14:10]);
			PLLCG_DIV3_ADDR: w = pllcg_div_word(s.div_en[3], s.div_ratio[19:15]);
			default: w = 32'h00000000;
		endcase
		read_mux = w;
	endfunction : read_mux

	always_comb begin
		next_st = st;
		next_st.ack = reg_write | reg_read;
		next_st.rdata = reg_read ? read_mux(st, reg_addr) : 32'h00000000;
		next_st.pll_prev = pll_output_clock;
		if (!st.stable) begin
			if (st.stable_cnt >= 32'(STABLE_COUNT - 1)) begin
				next_st.stable = 1'b1;
			end else begin
				next_st.stable_cnt = st.stable_cnt + 32'h00000001;
			end
		end
		if (path_switch) begin
			next_st.path_eff = st.path_select;
		end
		if (reg_write) begin
			case (reg_addr)
				PLLCG_CSR_ADDR: begin
					// only bits 0, 1 and 3 are stored
					next_st.path_select = reg_wdata[PLLCG_PATH_BIT];
					next_st.power_down  = reg_wdata[PLLCG_PWRDN_BIT];
					next_st.reset_hold  = reg_wdata[PLLCG_RST_BIT];
				end
				PLLCG_MULT_ADDR: begin
					if (pllcg_mult_ok(reg_wdata[4:0])) begin
						next_st.mult = reg_wdata[4:0];
					end
				end
				PLLCG_DIV0_ADDR: begin
					next_st.div_en[0] = reg_wdata[PLLCG_DIV_EN_BIT];
					next_st.div_ratio[4:0] = reg_wdata[4:0];
				end
				PLLCG_DIV1_ADDR: begin
					next_st.div_en[1] = reg_wdata[PLLCG_DIV_EN_BIT];
					next_st.div_ratio[9:5] = reg_wdata[4:0];
				end
				PLLCG_DIV2_ADDR: begin
					next_st.div_en[2] = reg_wdata[PLLCG_DIV_EN_BIT];
					next_st.div_ratio[14:10] = reg_wdata[4:0];
				end
				PLLCG_DIV3_ADDR: begin
					next_st.div_en[3] = reg_wdata[PLLCG_DIV_EN_BIT];
					next_st.div_ratio[19:15] = reg_wdata[4:0];
				end
				default: begin
					next_st.ack = 1'b1;
				end
			endcase
		end
		// external pin taken as a level; internal clock as the divider tick
		next_st.memif_clk = memif_clock_source_select ?
			external_memif_clock_in : memif_tick;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.reset_hold <= PLLCG_RST_RESET;
			st.path_select <= PLLCG_PATH_RESET;
			st.path_eff <= PLLCG_PATH_RESET;
			st.power_down <= PLLCG_PWRDN_RESET;
			st.mult <= PLLCG_MULT_RESET;
			st.div_en <= {4{PLLCG_DIV_EN_RESET}};
			st.div_ratio <= {PLLCG_DIV3_RESET, PLLCG_DIV2_RESET,
			                 PLLCG_DIV1_RESET, PLLCG_DIV0_RESET};
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// post-dividers
	// ------------------------------------------------------------
	pllcg_post_divider u_core_div (
		.clock    (clock),
		.rst      (rst),
		.src_tick (src_tick),
		.restart  (path_switch),
		.ratio    (st.div_ratio[9:5]),
		.enable   (st.div_en[1]),
		.tick     (core_tick)
	);

	pllcg_post_divider u_periph_div (
		.clock    (clock),
		.rst      (rst),
		.src_tick (src_tick),
		.restart  (path_switch),
		.ratio    (st.div_ratio[14:10]),
		.enable   (st.div_en[2]),
		.tick     (periph_tick)
	);

	// third system clock from the same selected path
	pllcg_post_divider u_memif_div (
		.clock    (clock),
		.rst      (rst),
		.src_tick (src_tick),
		.restart  (path_switch),
		.ratio    (st.div_ratio[19:15]),
		.enable   (st.div_en[3]),
		.tick     (memif_tick)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata = st.rdata;
	assign reg_ack = st.ack;
	assign pll_reset_hold = st.reset_hold;
	assign pll_power_down = st.power_down;
	assign pll_multiplier = st.mult;
	assign input_prescaler = st.div_ratio[4:0];
	assign core_clock = core_tick;
	assign peripheral_bus_clock = periph_tick;
	assign peripheral_clock_output_pin = periph_tick;
	assign memif_internal_clock = memif_tick;
	assign memif_clock = st.memif_clk;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
		$past(reg_read) && $past(reg_addr) == PLLCG_CSR_ADDR
		|-> reg_rdata[31:7] == 25'h0 && reg_rdata[5:4] == 2'h0
		&& reg_rdata[2] == 1'b0)
		else $error("reserved status bits read nonzero");
	a_reset_hold_wr: assert property (@(posedge clock) disable iff (rst)
		reg_write && reg_addr == PLLCG_CSR_ADDR
		|=> pll_reset_hold == $past(reg_wdata[PLLCG_RST_BIT]))
		else $error("pll reset hold did not follow write");
	a_power_down_wr: assert property (@(posedge clock) disable iff (rst)
		reg_write && reg_addr == PLLCG_CSR_ADDR
		|=> pll_power_down == $past(reg_wdata[PLLCG_PWRDN_BIT]))
		else $error("pll power down did not follow write");
	a_path_boundary: assert property (@(posedge clock) disable iff (rst)
		$changed(st.path_eff) |-> $past(core_tick))
		else $error("clock path switched off a core boundary");
	// a tick marks a boundary, so the ratio behind it is the one in force
	a_bypass_ticks: assert property (@(posedge clock) disable iff (rst)
		!st.path_eff && !path_switch && core_clock && st.div_en[1]
		&& $past(st.div_ratio[9:5]) == 5'h00 |=> core_clock)
		else $error("bypass divide by one missed a cycle");
	a_stable_count: assert property (@(posedge clock) disable iff (rst)
		$rose(st.stable) |-> st.stable_cnt == 32'(STABLE_COUNT - 1))
		else $error("stable rose before count finished");
	a_mult_valid: assert property (@(posedge clock) disable iff (rst)
		pllcg_mult_ok(pll_multiplier))
		else $error("multiplier holds a reserved code");
	a_memif_select: assert property (@(posedge clock) disable iff (rst)
		$past(memif_clock_source_select)
		|-> memif_clock == $past(external_memif_clock_in))
		else $error("memory clock not taken from external pin");
	a_pin_mirror: assert property (@(posedge clock) disable iff (rst)
		peripheral_clock_output_pin == peripheral_bus_clock)
		else $error("peripheral pin differs from bus clock");

endmodule : pllcg_clock_control

// file: hw/pllcg_post_divider.sv
// post-divider: one output tick per ratio+1 source ticks
`timescale 1ns/1ps
module pllcg_post_divider
	import pllcg_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// source and control
	input  wire logic       src_tick,
	input  wire logic       restart,
	input  wire logic [4:0] ratio,
	input  wire logic       enable,
	// divided clock
	output logic            tick
);

	typedef struct packed {
		logic [4:0] cnt;
		logic [4:0] ratio_act;
		logic       tick;
	} pllcg_div_state_t;

	pllcg_div_state_t st;
	pllcg_div_state_t next_st;

	// a new ratio is taken at a period boundary, or on restart, which also clears the count
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (restart) begin
			next_st.cnt = 5'h00;
			next_st.ratio_act = ratio;
		end else if (src_tick) begin
			if (st.cnt == st.ratio_act) begin
				next_st.cnt = 5'h00;
				next_st.ratio_act = ratio;
				next_st.tick = enable;
			end else begin
				next_st.cnt = st.cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

	a_div_disabled_quiet: assert property (@(posedge clock) disable iff (rst)
		!$past(enable) |-> !tick)
		else $error("disabled divider produced a tick");

endmodule : pllcg_post_divider
